// [design/serial_port_defines.vh]
`ifndef SERIAL_PORT_DEFINES_VH
`define SERIAL_PORT_DEFINES_VH

// register addresses
`define ADDR_MODE 3'h0
`define ADDR_CONTROL 3'h1
`define ADDR_STATUS 3'h2
`define ADDR_TX_DATA 3'h3
`define ADDR_RX_DATA 3'h4

// control_reg fields
`define CTL_TX_EMPTY_IRQ_EN 7
`define CTL_RX_IRQ_EN 6
`define CTL_TX_ON 5
`define CTL_RX_ON 4
`define CTL_ADDR_WAIT_EN 3
`define CTL_TX_DONE_IRQ_EN 2
`define CTL_CLK_SRC_EXT 1
`define CTL_CLK_OUT_EN 0

// mode_reg fields
`define MODE_SYNC_SEL 7
`define MODE_CHAR7 6
`define MODE_PARITY_EN 5
`define MODE_PARITY_ODD 4
`define MODE_TWO_STOP 3
`define MODE_ADDR_WAKE 2
`define MODE_PRESCALE_HI 1
`define MODE_PRESCALE_LO 0

// status_reg fields
`define ST_TX_BUF_EMPTY 7
`define ST_RX_BUF_FULL 6
`define ST_OVERRUN_ERR 5
`define ST_FRAMING_ERR 4
`define ST_PARITY_ERR 3
`define ST_TX_DONE 2
`define ST_ADDR_FLAG_RX 1
`define ST_ADDR_FLAG_TX 0

// reset values
`define CONTROL_RESET 8'h00
`define MODE_RESET 8'h00
`define STATUS_RESET 8'h84

// oversampling: sixteen ticks per bit, sample at the middle
`define OS_LAST 4'hF
`define OS_MID 4'h7

`endif

// [design/serial_port_control_irq.v]
// How it works
// - control register always read/write by CPU, zero after power-on reset.
// - bit 7 gates transmit-empty request raised by holding-to-shift transfer.
// - transmit-empty request goes by read-1-then-write-0 of flag, or enable clear.
// - bit 6 gates receive-full and receive-error requests.
// - receive requests go by read-1-then-write-0 of their flag, or enable clear.
// - with transmitter off, transmitter idle and empty flag held at one.
// - transmitter on: send starts after data written and empty flag cleared.
// - turning receiver off keeps all receive flags unchanged.
// - receiver on: start bit begins async frame, clock input begins clocked frame.
// - address-wait bit acts only when receiving in address-wake format.
// - while address-waiting, frames dropped, no flags, no errors, no requests.
// - address frame sets address flag, clears wait bit, resumes normal receive.
// - bit 2 gates transmit-done request: last bit sent, holding register empty.
// - transmit-done request goes by empty flag clear sequence, or enable clear.
// - bits 1 and 0 pick clock source and clock pin direction.
// - clock-out bit only counts in async mode with internal clock.
// - mode bit 7 picks async when 0, clocked when 1.
// - async internal clock output runs at the bit rate.
`timescale 1ns/1ps
`include "serial_port_defines.vh"

module serial_port_control_irq #(
  parameter RATE_DIV = 4
) (
  input wire ref_clk,
  input wire rst_b,
  input wire [2:0] addr,
  input wire [7:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [7:0] rdata,
  input wire rxd,
  output wire txd,
  input wire serial_clk_in,
  output wire serial_clk_out,
  output wire serial_clk_oe,
  output wire tx_empty_irq,
  output wire rx_full_irq,
  output wire rx_err_irq,
  output wire tx_done_irq
);

  localparam RX_IDLE = 2'd0;
  localparam RX_ASYNC = 2'd1;
  localparam RX_SYNC = 2'd2;

  reg [7:0] control_r;
  reg [7:0] mode_r;
  reg [7:0] status_r;
  reg [7:0] status_nxt;
  reg [4:0] armed_r;
  reg [7:0] tx_hold_r;
  reg [7:0] rx_hold_r;
  reg [1:0] rxd_s;
  reg [1:0] sck_s;
  reg sck_prev_r;
  reg [13:0] pre_cnt_r;
  reg [3:0] os_phase_r;
  reg [12:0] tx_sh_r;
  reg [3:0] tx_left_r;
  reg tx_active_r;
  reg tx_rose_r;
  reg [1:0] rx_state_r;
  reg [3:0] rx_sub_r;
  reg [3:0] rx_idx_r;
  reg [7:0] rx_data_r;
  reg rx_extra_r;
  reg rx_par_r;
  wire tx_on = control_r[`CTL_TX_ON];
  wire rx_on = control_r[`CTL_RX_ON];
  wire ext_clk = control_r[`CTL_CLK_SRC_EXT];
  wire sync_mode = mode_r[`MODE_SYNC_SEL];
  wire char7 = mode_r[`MODE_CHAR7] & ~sync_mode;
  wire addr_fmt = mode_r[`MODE_ADDR_WAKE] & ~sync_mode;
  wire par_en = mode_r[`MODE_PARITY_EN] & ~sync_mode & ~addr_fmt;
  wire has_extra = addr_fmt | par_en;
  // address wait only in address-wake format
  wire addr_wait = control_r[`CTL_ADDR_WAIT_EN] & addr_fmt;

  wire sck_rise = sck_s[1] & ~sck_prev_r;
  wire sck_fall = ~sck_s[1] & sck_prev_r;
  // prescale from mode bits 1:0 and the rate divider
  reg [13:0] pre_last;
  always @* begin
    case (mode_r[`MODE_PRESCALE_HI:`MODE_PRESCALE_LO])
      2'b00: pre_last = RATE_DIV[13:0] - 14'h0001;
      2'b01: pre_last = {RATE_DIV[11:0], 2'b00} - 14'h0001;
      2'b10: pre_last = {RATE_DIV[9:0], 4'h0} - 14'h0001;
      default: pre_last = {RATE_DIV[7:0], 6'h00} - 14'h0001;
    endcase
  end

  wire int_tick = (pre_cnt_r >= pre_last);
  // external async clock counts as the sixteen-times tick
  wire os_tick = ext_clk ? (sck_rise & ~sync_mode) : int_tick;
  wire bit_wrap = os_tick & (os_phase_r == `OS_LAST);
  wire bit_mid = os_tick & (os_phase_r == `OS_MID);
  // clocked mode edges: internal clock runs only during a transmit frame
  wire sync_fall = ext_clk ? sck_fall : (tx_active_r & bit_wrap);
  wire sync_rise = ext_clk ? sck_rise : (tx_active_r & bit_mid);
  // clock-out bit ignored in clocked mode or with external clock
  assign serial_clk_oe = ~ext_clk & (sync_mode | control_r[`CTL_CLK_OUT_EN]);
  // bit-rate clock from the oversampling phase
  assign serial_clk_out = sync_mode ? (tx_active_r ? os_phase_r[3] : 1'b1) : os_phase_r[3];
  assign txd = tx_active_r ? tx_sh_r[0] : 1'b1;
  assign tx_empty_irq = control_r[`CTL_TX_EMPTY_IRQ_EN] & status_r[`ST_TX_BUF_EMPTY];
  assign rx_full_irq = control_r[`CTL_RX_IRQ_EN] & status_r[`ST_RX_BUF_FULL];
  assign rx_err_irq = control_r[`CTL_RX_IRQ_EN] &
                      (status_r[`ST_OVERRUN_ERR] | status_r[`ST_FRAMING_ERR] | status_r[`ST_PARITY_ERR]);
  assign tx_done_irq = control_r[`CTL_TX_DONE_IRQ_EN] & status_r[`ST_TX_DONE];
  // pin synchronisers
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rxd_s <= 2'b11;
      sck_s <= 2'b11;
      sck_prev_r <= 1'b1;
    end else begin
      rxd_s <= {rxd_s[0], rxd};
      sck_s <= {sck_s[0], serial_clk_in};
      sck_prev_r <= sck_s[1];
    end
  end

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_cnt_r <= 14'h0000;
      os_phase_r <= 4'h0;
    end else begin
      pre_cnt_r <= int_tick ? 14'h0000 : pre_cnt_r + 14'h0001;
      if (os_tick)
        os_phase_r <= os_phase_r + 4'h1;
    end
  end

  // transmit frame image, start bit first, ones beyond the stop bits
  wire tx_extra = addr_fmt ? status_r[`ST_ADDR_FLAG_TX] :
                  (^(tx_hold_r & {~char7, 7'h7F}) ^ mode_r[`MODE_PARITY_ODD]);
  reg [8:0] tx_pay;
  always @* begin
    if (char7)
      tx_pay = has_extra ? {1'b1, tx_extra, tx_hold_r[6:0]} : {2'b11, tx_hold_r[6:0]};
    else
      tx_pay = has_extra ? {tx_extra, tx_hold_r} : {1'b1, tx_hold_r};
  end
  wire [3:0] tx_bits = 4'h2 + (char7 ? 4'h7 : 4'h8) + {3'b000, has_extra} +
                       {3'b000, mode_r[`MODE_TWO_STOP]};
  // start once holding register is valid; load on a bit boundary so the start bit is full length
  wire tx_load = tx_on & ~tx_active_r & ~status_r[`ST_TX_BUF_EMPTY] &
                 ((sync_mode & ext_clk) | bit_wrap);
  wire tx_step = sync_mode ? (sync_fall & tx_rose_r) : bit_wrap;
  wire tx_last = tx_active_r & tx_step & (tx_left_r == 4'h1);

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_sh_r <= 13'h1FFF;
      tx_left_r <= 4'h0;
      tx_active_r <= 1'b0;
      tx_rose_r <= 1'b0;
    end else if (!tx_on) begin
      tx_active_r <= 1'b0;
      tx_left_r <= 4'h0;
      tx_rose_r <= 1'b0;
    end else if (tx_load) begin
      tx_active_r <= 1'b1;
      tx_rose_r <= 1'b0;
      tx_sh_r <= sync_mode ? {5'h1F, tx_hold_r} : {3'b111, tx_pay, 1'b0};
      tx_left_r <= sync_mode ? 4'h8 : tx_bits;
    end else if (tx_active_r) begin
      if (sync_rise)
        tx_rose_r <= 1'b1;
      if (tx_step) begin
        tx_sh_r <= {1'b1, tx_sh_r[12:1]};
        tx_left_r <= tx_left_r - 4'h1;
        tx_rose_r <= 1'b0;
        if (tx_left_r == 4'h1)
          tx_active_r <= 1'b0;
      end
    end
  end

  // receiver
  wire [3:0] rx_bits = 4'h2 + (char7 ? 4'h7 : 4'h8) + {3'b000, has_extra};
  reg rx_done;
  reg rx_stop_ok;
  reg rx_par_ok;
  reg rx_addr_bit;
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_state_r <= RX_IDLE;
      rx_sub_r <= 4'h0;
      rx_idx_r <= 4'h0;
      rx_data_r <= 8'h00;
      rx_extra_r <= 1'b0;
      rx_par_r <= 1'b0;
    end else if (!rx_on) begin
      rx_state_r <= RX_IDLE;
    end else begin
      case (rx_state_r)
        RX_IDLE: begin
          rx_idx_r <= 4'h0;
          rx_sub_r <= 4'h0;
          rx_data_r <= 8'h00;
          rx_par_r <= 1'b0;
          // start bit or clock input starts a frame
          if (sync_mode) begin
            if (sync_rise) begin
              rx_data_r <= {rxd_s[1], 7'h00};
              rx_idx_r <= 4'h1;
              rx_state_r <= RX_SYNC;
            end
          end else if (os_tick & ~rxd_s[1]) begin
            rx_sub_r <= 4'h1;
            rx_state_r <= RX_ASYNC;
          end
        end
        RX_ASYNC: begin
          if (os_tick) begin
            rx_sub_r <= rx_sub_r + 4'h1;
            if (rx_sub_r == `OS_MID) begin
              rx_idx_r <= rx_idx_r + 4'h1;
              if (rx_idx_r == 4'h0) begin
                if (rxd_s[1])
                  rx_state_r <= RX_IDLE;
              end else if (rx_idx_r <= (char7 ? 4'h7 : 4'h8)) begin
                rx_data_r <= char7 ? {1'b0, rxd_s[1], rx_data_r[6:1]} : {rxd_s[1], rx_data_r[7:1]};
                rx_par_r <= rx_par_r ^ rxd_s[1];
              end else if (rx_idx_r == rx_bits - 4'h1) begin
                rx_state_r <= RX_IDLE;
              end else begin
                rx_extra_r <= rxd_s[1];
              end
            end
          end
        end
        RX_SYNC: begin
          if (sync_rise) begin
            rx_data_r <= {rxd_s[1], rx_data_r[7:1]};
            rx_idx_r <= rx_idx_r + 4'h1;
            if (rx_idx_r == 4'h7)
              rx_state_r <= RX_IDLE;
          end
        end
        default: rx_state_r <= RX_IDLE;
      endcase
    end
  end

  // frame completes on the stop-bit sample or the eighth clocked bit
  always @* begin
    rx_done = 1'b0;
    rx_stop_ok = 1'b1;
    if (rx_on && rx_state_r == RX_ASYNC && os_tick && rx_sub_r == `OS_MID &&
        rx_idx_r == rx_bits - 4'h1) begin
      rx_done = 1'b1;
      rx_stop_ok = rxd_s[1];
    end
    if (rx_on && rx_state_r == RX_SYNC && sync_rise && rx_idx_r == 4'h7)
      rx_done = 1'b1;
    rx_par_ok = ~par_en | ((rx_par_r ^ rx_extra_r) == mode_r[`MODE_PARITY_ODD]);
    rx_addr_bit = addr_fmt & rx_extra_r;
  end
  wire [7:0] rx_word = sync_mode ? {rxd_s[1], rx_data_r[7:1]} : rx_data_r;

  // register writes, status flags
  wire wr_ctl = wr_stb & (addr == `ADDR_CONTROL);
  wire wr_st = wr_stb & (addr == `ADDR_STATUS);
  wire rd_st = rd_stb & (addr == `ADDR_STATUS);
  wire addr_hit = rx_done & addr_wait & rx_addr_bit;
  wire rx_accept = rx_done & (~addr_wait | rx_addr_bit);

  always @* begin
    status_nxt = status_r;
    // clear only a flag that was read as one
    if (wr_st) begin
      if (armed_r[4] & ~wdata[`ST_TX_BUF_EMPTY]) begin
        status_nxt[`ST_TX_BUF_EMPTY] = 1'b0;
        status_nxt[`ST_TX_DONE] = 1'b0;
      end
      if (armed_r[3] & ~wdata[`ST_RX_BUF_FULL])
        status_nxt[`ST_RX_BUF_FULL] = 1'b0;
      if (armed_r[2] & ~wdata[`ST_OVERRUN_ERR])
        status_nxt[`ST_OVERRUN_ERR] = 1'b0;
      if (armed_r[1] & ~wdata[`ST_FRAMING_ERR])
        status_nxt[`ST_FRAMING_ERR] = 1'b0;
      if (armed_r[0] & ~wdata[`ST_PARITY_ERR])
        status_nxt[`ST_PARITY_ERR] = 1'b0;
      status_nxt[`ST_ADDR_FLAG_TX] = wdata[`ST_ADDR_FLAG_TX];
    end
    // transfer to shift register sets empty flag
    if (tx_load)
      status_nxt[`ST_TX_BUF_EMPTY] = 1'b1;
    if (tx_load)
      status_nxt[`ST_TX_DONE] = 1'b0;
    // last bit out with holding register empty
    if (tx_last & status_nxt[`ST_TX_BUF_EMPTY])
      status_nxt[`ST_TX_DONE] = 1'b1;
    if (!tx_on) begin
      status_nxt[`ST_TX_BUF_EMPTY] = 1'b1;
      status_nxt[`ST_TX_DONE] = 1'b1;
    end
    // hardware changes receive flags only on an accepted frame
    if (rx_accept) begin
      if (addr_fmt)
        status_nxt[`ST_ADDR_FLAG_RX] = rx_extra_r;
      if (status_r[`ST_RX_BUF_FULL])
        status_nxt[`ST_OVERRUN_ERR] = 1'b1;
      else
        status_nxt[`ST_RX_BUF_FULL] = 1'b1;
      if (!rx_stop_ok)
        status_nxt[`ST_FRAMING_ERR] = 1'b1;
      if (!rx_par_ok)
        status_nxt[`ST_PARITY_ERR] = 1'b1;
    end
  end

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      control_r <= `CONTROL_RESET;
      mode_r <= `MODE_RESET;
      status_r <= `STATUS_RESET;
      armed_r <= 5'h00;
      tx_hold_r <= 8'h00;
      rx_hold_r <= 8'h00;
      rdata <= 8'h00;
    end else begin
      if (wr_ctl)
        control_r <= wdata;
      // hardware clears wait bit, winning over a write
      if (addr_hit)
        control_r[`CTL_ADDR_WAIT_EN] <= 1'b0;
      if (wr_stb && addr == `ADDR_MODE)
        mode_r <= wdata;
      if (wr_stb && addr == `ADDR_TX_DATA)
        tx_hold_r <= wdata;
      if (rx_accept && !status_r[`ST_RX_BUF_FULL])
        rx_hold_r <= rx_word;
      status_r <= status_nxt;
      if (rd_st)
        armed_r <= armed_r | status_r[7:3];
      else if (wr_st)
        armed_r <= 5'h00;
      case (addr)
        `ADDR_MODE: rdata <= rd_stb ? mode_r : 8'h00;
        `ADDR_CONTROL: rdata <= rd_stb ? control_r : 8'h00;
        `ADDR_STATUS: rdata <= rd_stb ? status_r : 8'h00;
        `ADDR_TX_DATA: rdata <= rd_stb ? tx_hold_r : 8'h00;
        `ADDR_RX_DATA: rdata <= rd_stb ? rx_hold_r : 8'h00;
        default: rdata <= 8'h00;
      endcase
    end
  end

endmodule

// [tb/serial_port_control_irq_properties.sv]
`timescale 1ns/1ps
module serial_port_control_irq_properties #(
  parameter RATE_DIV = 4
) (
  input wire ref_clk,
  input wire rst_b,
  input wire [2:0] addr,
  input wire [7:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  input wire [7:0] rdata,
  input wire rxd,
  input wire txd,
  input wire serial_clk_in,
  input wire serial_clk_out,
  input wire serial_clk_oe,
  input wire tx_empty_irq,
  input wire rx_full_irq,
  input wire rx_err_irq,
  input wire tx_done_irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire ctl_wr = wr_stb && addr == 3'h1;
  AST_RDATA_IDLE: assert property (!$past(rd_stb) |-> rdata == 8'h00)
    else $error("read data not zero outside read slot");
  AST_CTRL_READBACK: assert property (ctl_wr ##2 (rd_stb && addr == 3'h1) |=>
    (rdata & 8'hF7) == ($past(wdata, 3) & 8'hF7)) else $error("control readback differs");
  AST_UNMAPPED: assert property (rd_stb && addr > 3'h4 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_TXE_MASK: assert property (ctl_wr && !wdata[7] |=> !tx_empty_irq)
    else $error("tx empty request not masked");
  AST_RX_MASK: assert property (ctl_wr && !wdata[6] |=> !rx_full_irq && !rx_err_irq)
    else $error("receive requests not masked");
  AST_TXDONE_MASK: assert property (ctl_wr && !wdata[2] |=> !tx_done_irq)
    else $error("tx done request not masked");
  AST_TXOFF_EMPTY: assert property (ctl_wr && !wdata[5] && wdata[7] |-> ##[1:2] tx_empty_irq)
    else $error("tx empty not forced with transmitter off");
  AST_EXT_NO_DRIVE: assert property (ctl_wr && wdata[1] |=> !serial_clk_oe)
    else $error("clock pin driven with external clock");
  AST_RXOFF_KEEP: assert property (ctl_wr && !wdata[4] && wdata[6] && rx_full_irq |=> rx_full_irq)
    else $error("receiver off lost full flag");
  cover property ($rose(tx_done_irq));
  cover property ($rose(rx_full_irq));
  cover property ($rose(rx_err_irq));
endmodule

bind serial_port_control_irq serial_port_control_irq_properties #(.RATE_DIV(RATE_DIV)) u_props (
  .ref_clk(ref_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
  .rdata(rdata), .rxd(rxd), .txd(txd), .serial_clk_in(serial_clk_in), .serial_clk_out(serial_clk_out),
  .serial_clk_oe(serial_clk_oe), .tx_empty_irq(tx_empty_irq), .rx_full_irq(rx_full_irq),
  .rx_err_irq(rx_err_irq), .tx_done_irq(tx_done_irq));

// [tb/remote_station.sv]
`timescale 1ns/1ps
module remote_station (
  output logic rxd,
  output logic serial_clk_in
);
  initial begin
    rxd = 1'b1;
    serial_clk_in = 1'b0;
  end
  task send(input logic [10:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      rxd = bits[i];
      repeat (16) begin
        #62.5 serial_clk_in = 1'b1;
        #62.5 serial_clk_in = 1'b0;
      end
    end
    rxd = 1'b1;
  endtask
endmodule

// [tb/tb.sv]
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_fail++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
`define WAIT(c) begin k = 0; while (!(c) && k < 4000) begin @(negedge ref_clk); k++; end \
  if (k >= 4000) begin n_fail++; end_of_test(); end end
module tb;
  logic ref_clk, rst_b, wr_stb, rd_stb;
  logic [2:0] addr;
  logic [7:0] wdata, s;
  wire [7:0] rdata;
  wire rxd, txd, sclk_ext, sclk_out, sclk_oe, txe_irq, rxf_irq, rxe_irq, txd_irq;
  int n_fail, comparisons, k, p;
  logic [16:0] cp [7] = '{{8'h00, 8'h00, 1'b0}, {8'h00, 8'h01, 1'b1}, {8'h00, 8'h02, 1'b0},
    {8'h00, 8'h03, 1'b0}, {8'h80, 8'h00, 1'b1}, {8'h80, 8'h01, 1'b1}, {8'h80, 8'h03, 1'b0}};
  // pin level: device drives when enabled, else the station
  wire sclk_pin = sclk_oe ? sclk_out : sclk_ext;

  serial_port_control_irq #(.RATE_DIV(1)) u_serial_port_control_irq (
    .ref_clk(ref_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .rxd(rxd), .txd(txd), .serial_clk_in(sclk_pin),
    .serial_clk_out(sclk_out), .serial_clk_oe(sclk_oe), .tx_empty_irq(txe_irq),
    .rx_full_irq(rxf_irq), .rx_err_irq(rxe_irq), .tx_done_irq(txd_irq));
  remote_station u_remote_station (.rxd(rxd), .serial_clk_in(sclk_ext));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
    @(negedge ref_clk);
  endtask

  task rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    @(negedge ref_clk);
    d = rdata;
  endtask

  task end_of_test;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    rst_b = 1'b0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(3'h1, s); `CHK(s, 8'h00)
    rd(3'h2, s); `CHK(s, 8'h84)
    `CHK({txe_irq, rxf_irq, rxe_irq, txd_irq}, 4'h0)
    wr(3'h0, 8'h00);
    wr(3'h1, 8'hA5);
    rd(3'h1, s); `CHK(s, 8'hA5)
    rd(3'h7, s); `CHK(s, 8'h00)
    $display("test registers done");
    wr(3'h1, 8'hA4); `CHK({txe_irq, txd_irq}, 2'b11)
    wr(3'h3, 8'h96);
    rd(3'h2, s);
    wr(3'h2, 8'h00);
    `WAIT(txd === 1'b0)
    `CHK(txe_irq, 1'b1)
    `CHK(txd_irq, 1'b0)
    repeat (8) @(negedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(negedge ref_clk);
      `CHK(txd, 8'h96 >> i & 8'h01)
    end
    wr(3'h1, 8'h24); `CHK(txe_irq, 1'b0)
    `WAIT(txd_irq === 1'b1)
    rd(3'h2, s); `CHK(s, 8'h84)
    wr(3'h2, 8'h00); `CHK(txd_irq, 1'b0)
    wr(3'h1, 8'h84);
    repeat (2) @(negedge ref_clk);
    `CHK({txe_irq, txd_irq}, 2'b11)
    rd(3'h2, s);
    wr(3'h2, 8'h00);
    rd(3'h2, s); `CHK(s[7], 1'b1)
    $display("test transmit done");
    for (int j = 0; j < 7; j++) begin
      wr(3'h0, cp[j][16:9]);
      wr(3'h1, cp[j][8:1]); `CHK(sclk_oe, cp[j][0])
    end
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h01);
    `WAIT(sclk_out === 1'b0)
    `WAIT(sclk_out === 1'b1)
    `WAIT(sclk_out === 1'b0)
    p = k;
    `WAIT(sclk_out === 1'b1)
    `CHK(p + k, 16)
    $display("test clock pin done");
    wr(3'h1, 8'h52);
    u_remote_station.send({1'b1, 8'h3C, 1'b0}, 10);
    `WAIT(rxf_irq === 1'b1)
    rd(3'h4, s); `CHK(s, 8'h3C)
    u_remote_station.send({1'b0, 8'hC3, 1'b0}, 10);
    `WAIT(rxe_irq === 1'b1)
    `CHK({rxf_irq, rxe_irq}, 2'b11)
    wr(3'h1, 8'h42); `CHK({rxf_irq, rxe_irq}, 2'b11)
    rd(3'h2, s); `CHK(s & 8'hE0, 8'hE0)
    wr(3'h2, 8'h00); `CHK({rxf_irq, rxe_irq}, 2'b00)
    $display("test receive done");
    wr(3'h0, 8'h04);
    wr(3'h1, 8'h5A);
    u_remote_station.send({1'b1, 1'b0, 8'h55, 1'b0}, 11);
    repeat (40) @(negedge ref_clk);
    `CHK({rxf_irq, rxe_irq}, 2'b00)
    u_remote_station.send({1'b1, 1'b1, 8'hA5, 1'b0}, 11);
    `WAIT(rxf_irq === 1'b1)
    rd(3'h1, s); `CHK(s, 8'h52)
    rd(3'h2, s); `CHK(s[1], 1'b1)
    rd(3'h4, s); `CHK(s, 8'hA5)
    $display("test address wake done");
    rd(3'h2, s);
    wr(3'h2, 8'h00); `CHK(rxf_irq, 1'b0)
    wr(3'h0, 8'h30);
    u_remote_station.send({1'b1, 1'b0, 8'h0F, 1'b0}, 11);
    `WAIT(rxe_irq === 1'b1)
    rd(3'h2, s); `CHK(s & 8'h78, 8'h48)
    rd(3'h4, s); `CHK(s, 8'h0F)
    $display("test parity done");
    end_of_test();
  end
endmodule
